/* File: sadc_pkg.sv */
package sadc_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CLKSEL = 4'h4;
  localparam logic [3:0] ADDR_RES_HI = 4'h8;
  localparam logic [3:0] ADDR_RES_LO = 4'hC;
  localparam logic [3:0] ADDR_FLAGS = 4'h0 + 4'h0 + 4'h0 + 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  // control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_GO = 1;
  localparam int CTL_CHS_LO = 2;
  localparam int CTL_CHS_HI = 5;
  localparam int CTL_REFSEL = 6;
  localparam int CTL_JUSTIFY = 7;
  // clock select field
  localparam int CKS_LO = 4;
  localparam int CKS_HI = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CKS_MASK = 8'h70;
  localparam logic [7:0] CKS_RESET = 8'h00;
  localparam logic [7:0] RES_RESET = 8'h00;
  localparam int RES_BITS = 10;
  // a conversion spans 11 bit periods; one settling period precedes the 10 decisions
  localparam logic [3:0] CONV_PERIODS = 4'hB;
  localparam logic [3:0] ABORT_PERIODS = 4'h2;
  // system clock and internal rc source
  localparam int CLK_HZ = 10_000_000;
  localparam int RC_MAX_HZ = 500_000;
  localparam logic [6:0] RC_DIV = 7'(CLK_HZ / RC_MAX_HZ);
  localparam logic [2:0] CKS_RC_LOW = 3'h3;
  typedef enum {ST_IDLE, ST_DELAY, ST_CONV, ST_HOLDOFF, ST_OFF} sadc_state_t;
  typedef struct packed {
    logic justify;
    logic refsel;
    logic [3:0] chan;
    logic go;
    logic enable;
  } sadc_ctl_t;
endpackage

/* File: sadc_sequencer.sv */
// How it works
// - control bit 7 set gives right-justified result, clear gives left-justified
// - converter runs only while the enable bit (bit 0) is one
// - writing one to bit 1 starts; it reads one while converting
// - completion clears go, sets done flag, loads both result bytes
// - clearing go early abandons conversion; result bytes keep old value
// - after abort wait two bit periods, then acquire on the selected channel
// - reset returns all registers to reset values, stopping conversions
// - with rc clock, start waits one extra instruction cycle
// - sleep with rc clock: wake if irq enabled, else shut down
// - sleep with other clock aborts and shuts down; enable stays set
// - special-event trigger sets go and clears the capture timer
// - channel codes 0-7 external, 12 comparator ref, 13 0.6V, 14 1.2V
// - control bit 6 selects external reference pin, else supply rail
// - clock field bits 6..4 pick fosc divide 2..64 or rc source
// - left layout: high byte bits 9..2, low byte bits 1..0 at 7..6
// - right layout: high byte bits 9..8 at 1..0, low byte bits 7..0
// - clock register bit 7 and bits 3..0 read zero
// - a full conversion takes 11 bit periods
// - done flag sets at every completion regardless of irq enable
//
// Local design decisions: the register addresses and the Wishbone slave port.
module sadc_sequencer (
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic reset_n_i, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // wishbone ack
  input wire logic instr_cycle_i, // one-cycle pulse per instruction cycle
  input wire logic sleep_i, // core is in sleep, level
  input wire logic irq_enable_i, // conversion_done_irq_enable
  input wire logic flag_clear_i, // software clears conversion_done_flag, pulse
  input wire logic special_trigger_i, // capture_compare_unit special event, pulse
  input wire logic comp_decision_i, // comparator: input at or above trial dac value
  output logic conversion_done_flag_o, // sticky completion flag
  output logic wake_o, // wake request from sleep
  output logic timer_clear_o, // clear capture_timer, pulse
  output logic [3:0] chan_o, // mux select to analog front end
  output logic ref_ext_o, // 1 external reference, 0 supply
  output logic sample_o, // sample-and-hold tracking
  output logic [9:0] dac_o, // trial value to comparator
  output logic analog_on_o // converter powered
);
  sadc_pkg::sadc_ctl_t ctl_r;
  logic [2:0] cks_r;
  logic [9:0] result_r;
  logic [9:0] trial_r;
  logic [9:0] sar_r;
  logic [3:0] step_r;
  logic [6:0] div_r;
  logic tad_r;
  logic off_r;
  sadc_pkg::sadc_state_t state_r;

  logic comp_s1_r, comp_s2_r, sleep_s1_r, sleep_s2_r;
  logic wr_ctl, rd_go_clear, go_set, is_rc, finish, abort;

  // analog decision and sleep come from outside the clock domain
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      comp_s1_r <= comp_decision_i;
      comp_s2_r <= comp_s1_r;
      sleep_s1_r <= sleep_i;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // decode of rc selection, used by start delay and sleep abort
  function automatic logic rc_selected(input logic [2:0] cks);
    rc_selected = (cks[1:0] == sadc_pkg::CKS_RC_LOW[1:0]);
  endfunction

  function automatic logic [6:0] div_limit(input logic [2:0] cks);
    case (cks)
      3'h0: div_limit = 7'h01;
      3'h4: div_limit = 7'h03;
      3'h1: div_limit = 7'h07;
      3'h5: div_limit = 7'h0F;
      3'h2: div_limit = 7'h1F;
      3'h6: div_limit = 7'h3F;
      default: div_limit = sadc_pkg::RC_DIV - 7'h01;
    endcase
  endfunction

  assign is_rc = rc_selected(cks_r);
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge on which the master samples ack, never earlier
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire wr_cks = bus_wr && (wb_adr_i == sadc_pkg::ADDR_CLKSEL);
  assign wr_ctl = bus_wr && (wb_adr_i == sadc_pkg::ADDR_CONTROL);
  assign rd_go_clear = wr_ctl && !wb_dat_i[sadc_pkg::CTL_GO];
  assign go_set = (wr_ctl && wb_dat_i[sadc_pkg::CTL_GO] && ctl_r.enable)
                  || (special_trigger_i && ctl_r.enable);
  assign finish = (state_r == sadc_pkg::ST_CONV) && tad_r && (step_r == 4'h0);
  // software clear or a sleep on a non-rc clock both abandon the conversion
  assign abort = ((state_r == sadc_pkg::ST_CONV) || (state_r == sadc_pkg::ST_DELAY))
                 && ((rd_go_clear && ctl_r.go) || (sleep_s2_r && !is_rc));

  // conversion bit period divider
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= 7'h00;
      tad_r <= 1'b0;
    end else if (state_r == sadc_pkg::ST_IDLE || state_r == sadc_pkg::ST_DELAY) begin
      // held through the start delay so the first period is a full one
      div_r <= 7'h00;
      tad_r <= 1'b0;
    end else if (div_r >= div_limit(cks_r)) begin
      div_r <= 7'h00;
      tad_r <= 1'b1;
    end else begin
      div_r <= div_r + 7'h01;
      tad_r <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= sadc_pkg::ST_IDLE;
      step_r <= 4'h0;
      trial_r <= 10'h000;
      sar_r <= 10'h000;
      off_r <= 1'b0;
    end else if (!ctl_r.enable) begin
      state_r <= sadc_pkg::ST_IDLE;
      off_r <= 1'b0;
    end else begin
      case (state_r)
        sadc_pkg::ST_IDLE: begin
          if (off_r && !sleep_s2_r)
            off_r <= 1'b0;
          if (go_set) begin
            state_r <= is_rc ? sadc_pkg::ST_DELAY : sadc_pkg::ST_CONV;
            step_r <= sadc_pkg::CONV_PERIODS - 4'h1;
            sar_r <= 10'h000;
            trial_r <= 10'h200;
            off_r <= 1'b0;
          end
        end
        sadc_pkg::ST_DELAY: begin
          if (abort) begin
            state_r <= sadc_pkg::ST_HOLDOFF;
            step_r <= sadc_pkg::ABORT_PERIODS;
          end else if (instr_cycle_i)
            state_r <= sadc_pkg::ST_CONV;
        end
        sadc_pkg::ST_CONV: begin
          if (abort) begin
            state_r <= sadc_pkg::ST_HOLDOFF;
            step_r <= sadc_pkg::ABORT_PERIODS;
            off_r <= sleep_s2_r;
          end else if (tad_r) begin
            // first period settles; then one decision per period, msb first
            if (step_r != sadc_pkg::CONV_PERIODS - 4'h1) begin
              if (comp_s2_r)
                sar_r <= trial_r | sar_r;
              trial_r <= trial_r >> 1;
            end
            if (step_r == 4'h0) begin
              state_r <= sadc_pkg::ST_IDLE;
              off_r <= sleep_s2_r && !irq_enable_i;
            end else begin
              step_r <= step_r - 4'h1;
            end
          end
        end
        sadc_pkg::ST_HOLDOFF: begin
          if (tad_r) begin
            if (step_r <= 4'h1)
              state_r <= sadc_pkg::ST_IDLE;
            else
              step_r <= step_r - 4'h1;
          end
        end
        default: state_r <= sadc_pkg::ST_IDLE;
      endcase
    end
  end

  // last decision merged in at completion
  wire [9:0] final_val = (comp_s2_r && trial_r != 10'h000) ? (sar_r | trial_r) : sar_r;

  // registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_r <= sadc_pkg::CTL_RESET;
      cks_r <= 3'h0;
      result_r <= 10'h000;
    end else begin
      if (wr_ctl) begin
        ctl_r.justify <= wb_dat_i[sadc_pkg::CTL_JUSTIFY];
        ctl_r.refsel <= wb_dat_i[sadc_pkg::CTL_REFSEL];
        ctl_r.chan <= wb_dat_i[sadc_pkg::CTL_CHS_HI:sadc_pkg::CTL_CHS_LO];
        ctl_r.enable <= wb_dat_i[sadc_pkg::CTL_ENABLE];
      end
      if (wr_cks)
        cks_r <= wb_dat_i[sadc_pkg::CKS_HI:sadc_pkg::CKS_LO];
      if (finish || abort || (wr_ctl && !wb_dat_i[sadc_pkg::CTL_ENABLE]))
        ctl_r.go <= 1'b0;
      else if (go_set && state_r == sadc_pkg::ST_IDLE)
        ctl_r.go <= 1'b1;
      if (finish)
        result_r <= final_val;
    end
  end

  // flag: a completion in the clear cycle wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conversion_done_flag_o <= 1'b0;
      wake_o <= 1'b0;
      timer_clear_o <= 1'b0;
    end else begin
      if (finish)
        conversion_done_flag_o <= 1'b1;
      else if (flag_clear_i)
        conversion_done_flag_o <= 1'b0;
      wake_o <= finish && sleep_s2_r && irq_enable_i;
      timer_clear_o <= special_trigger_i && ctl_r.enable;
    end
  end

  // front end drive
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_o <= 4'h0;
      ref_ext_o <= 1'b0;
      sample_o <= 1'b0;
      dac_o <= 10'h000;
      analog_on_o <= 1'b0;
    end else begin
      chan_o <= ctl_r.chan;
      ref_ext_o <= ctl_r.refsel;
      sample_o <= ctl_r.enable && !off_r && (state_r == sadc_pkg::ST_IDLE);
      dac_o <= sar_r | trial_r;
      analog_on_o <= ctl_r.enable && !off_r;
    end
  end

  // read mux with layout selection
  function automatic logic [7:0] read_byte(input logic [3:0] adr, input logic [9:0] res,
                                           input logic just);
    case (adr)
      sadc_pkg::ADDR_CONTROL: read_byte = ctl_r;
      sadc_pkg::ADDR_CLKSEL: read_byte = {1'b0, cks_r, 4'h0};
      sadc_pkg::ADDR_RES_HI: read_byte = just ? {6'h00, res[9:8]} : res[9:2];
      sadc_pkg::ADDR_RES_LO: read_byte = just ? res[7:0] : {res[1:0], 6'h00};
      default: read_byte = 8'h00;
    endcase
  endfunction

  // single-wait-state slave; unmapped addresses read zero and still ack
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, read_byte(wb_adr_i, result_r, ctl_r.justify)}
                          : 32'h0000_0000;
    end
  end

  chk_go_clears_finish: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    finish |=> !ctl_r.go && conversion_done_flag_o) else $error("completion mishandled");
  chk_abort_keeps_result: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    abort |=> $stable(result_r)) else $error("abort changed result");
  chk_off_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctl_r.enable |=> state_r == sadc_pkg::ST_IDLE) else $error("disabled but busy");
  chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    conversion_done_flag_o && !flag_clear_i |=> conversion_done_flag_o)
    else $error("flag lost");
  chk_clk_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cks_r == $past(cks_r)) || $past(wr_cks))
    else $error("clock select moved");
  chk_rc_delay: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_r == sadc_pkg::ST_IDLE && go_set && is_rc && ctl_r.enable
    |=> state_r == sadc_pkg::ST_DELAY) else $error("rc start not delayed");
  chk_trigger_timer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    special_trigger_i && ctl_r.enable |=> timer_clear_o) else $error("timer not cleared");
  chk_sleep_abort: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_r == sadc_pkg::ST_CONV && sleep_s2_r && !is_rc && ctl_r.enable
    |=> state_r == sadc_pkg::ST_HOLDOFF ##0 ctl_r.enable) else $error("sleep no abort");

  // helper: clocks spent in the conversion state, compared at completion
  // limitation: a clock select change in mid-conversion makes this count meaningless
  logic [9:0] conv_clks_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_clks_r <= 10'h000;
    end else if (state_r != sadc_pkg::ST_CONV) begin
      conv_clks_r <= 10'h000;
    end else begin
      conv_clks_r <= conv_clks_r + 10'h001;
    end
  end

  chk_conv_length: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    finish |-> conv_clks_r == 10'(sadc_pkg::CONV_PERIODS) * (10'(div_limit(cks_r)) + 10'h001))
    else $error("conversion length wrong");

  // abort recovery: the holdoff runs out, then the channel is tracked again
  sequence s_holdoff_ends;
    state_r == sadc_pkg::ST_HOLDOFF && tad_r && step_r <= 4'h1 && ctl_r.enable && !off_r;
  endsequence
  sequence s_tracking;
    ##1 sample_o;
  endsequence
  chk_hold_no_track: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_r == sadc_pkg::ST_HOLDOFF |-> !sample_o) else $error("tracking in holdoff");
  chk_track_after: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_holdoff_ends |=> s_tracking) else $error("no acquisition after holdoff");
  chk_abort_holdoff: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    abort && ctl_r.enable |=> state_r == sadc_pkg::ST_HOLDOFF && !ctl_r.go)
    else $error("abort not taken");

  // sleep handling with the rc source
  chk_wake_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    finish && sleep_s2_r && irq_enable_i |=> wake_o) else $error("no wake");
  chk_sleep_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    finish && sleep_s2_r && !irq_enable_i && ctl_r.enable
    |=> ##1 !analog_on_o && ctl_r.enable)
    else $error("converter left on in sleep");

  // front end routing follows the control register one clock later
  chk_chan_route: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 chan_o == $past(ctl_r.chan)) else $error("channel not routed");
  chk_ref_route: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 ref_ext_o == $past(ctl_r.refsel)) else $error("reference not routed");

  // read layouts; result and layout bit are taken from the cycle of the request
  chk_layout_high: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_req && !wb_we_i && wb_adr_i == sadc_pkg::ADDR_RES_HI
    |=> wb_dat_o == ($past(ctl_r.justify) ? {30'h0000_0000, $past(result_r[9:8])}
                     : {24'h00_0000, $past(result_r[9:2])}))
    else $error("high byte layout");
  chk_layout_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_req && !wb_we_i && wb_adr_i == sadc_pkg::ADDR_RES_LO
    |=> wb_dat_o == ($past(ctl_r.justify) ? {24'h00_0000, $past(result_r[7:0])}
                     : {24'h00_0000, $past(result_r[1:0]), 6'h00}))
    else $error("low byte layout");
  chk_clk_zero_bits: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_req && !wb_we_i && wb_adr_i == sadc_pkg::ADDR_CLKSEL
    |=> wb_dat_o[7] == 1'b0 && wb_dat_o[3:0] == 4'h0) else $error("clock bits not zero");

  // approximation steps
  chk_trial_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_r == sadc_pkg::ST_IDLE && go_set && ctl_r.enable
    |=> trial_r == 10'h200 && sar_r == 10'h000) else $error("trial not at msb");
  chk_trial_shift: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_r == sadc_pkg::ST_CONV && tad_r && !abort
    && step_r != (sadc_pkg::CONV_PERIODS - 4'h1)
    |=> trial_r == ($past(trial_r) >> 1)) else $error("trial not stepped");

  // status and flag
  chk_go_busy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ctl_r.go |-> state_r == sadc_pkg::ST_CONV || state_r == sadc_pkg::ST_DELAY)
    else $error("go without conversion");
  chk_disable_no_go: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctl_r.enable |-> !ctl_r.go) else $error("go while disabled");
  chk_flag_only_done: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !conversion_done_flag_o && !finish |=> !conversion_done_flag_o)
    else $error("flag set without completion");
  chk_flag_set_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    finish && flag_clear_i |=> conversion_done_flag_o) else $error("clear beat set");
endmodule

/* File: sadc_frontend_model.sv */
module sadc_frontend_model (
  input wire logic clk_i, // system clock
  input wire logic [9:0] vin_i, // analog level under test, in codes
  input wire logic [9:0] dac_i, // trial value from the sequencer
  input wire logic analog_on_i, // converter powered
  output logic comp_decision_o // 1 when input is at or above trial
);
  timeunit 1ns;
  timeprecision 1ns;
  // unpowered comparator toggles so a stale decision is never trusted
  always_ff @(posedge clk_i) begin
    comp_decision_o <= analog_on_i ? (vin_i >= dac_i) : ~comp_decision_o;
  end
endmodule

/* File: test_sar_adc_sequencer.sv */
module test_sar_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, reset_n_i = 0, cyc = 0, stb = 0, we = 0, instr = 0, fclr = 0, trig = 0;
  logic slp = 0, irqe = 0, seen_tclr = 0, seen_wake = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, wb_dat_o, q;
  logic wb_ack_o, comp, flag_o, wake_o, tclr_o, ref_ext_o, sample_o, aon;
  logic [3:0] chan_o;
  logic [9:0] dac_o, vin = 10'h000, prev;
  logic [63:0] expq[$];
  int miscompares = 0, n_tests = 0;
  logic [3:0] codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE};
  sadc_sequencer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr_cycle_i(instr), .sleep_i(slp), .irq_enable_i(irqe),
    .flag_clear_i(fclr), .special_trigger_i(trig), .comp_decision_i(comp),
    .conversion_done_flag_o(flag_o), .wake_o(wake_o), .timer_clear_o(tclr_o), .chan_o(chan_o),
    .ref_ext_o(ref_ext_o), .sample_o(sample_o), .dac_o(dac_o), .analog_on_o(aon));
  sadc_frontend_model fe (.clk_i(clk_i), .vin_i(vin), .dac_i(dac_o), .analog_on_i(aon),
    .comp_decision_o(comp));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // instruction tick every fourth cycle, needed by the rc start delay
  always @(posedge clk_i) instr <= ($time / 100) % 4 == 0;
  // one-cycle pulses are caught here so a check need not land on their cycle
  always @(posedge clk_i) begin
    if (tclr_o === 1'b1) seen_tclr <= 1'b1;
    if (wake_o === 1'b1) seen_wake <= 1'b1;
  end
  task automatic bad(input string m);
    $display("MISMATCH t=%0t %s", $time, m);
    miscompares++;
  endtask
  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) bad(m);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                    input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h00_0000, d};
    if (!w) expq.push_back({m, e});
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) bad("no ack");
    q = wb_dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  // result checker: every read answer is taken against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      logic [63:0] x;
      x = expq.pop_front();
      n_tests++;
      if ((wb_dat_o & x[63:32]) !== x[31:0]) bad("read data");
    end
  end
  task automatic poll_done();
    int n;
    n = 0;
    do begin
      wb(0, sadc_pkg::ADDR_CONTROL, 8'h00, 32'h0000_0000, 32'h0000_0000);
      n++;
    end while (q[sadc_pkg::CTL_GO] !== 1'b0 && n < 200);
    chk(n < 200, "go never cleared");
  endtask
  task automatic conv(input logic j, input logic [3:0] ch);
    logic [7:0] c;
    c = {j, 1'b0, ch, 2'b01};
    vin <= 10'($urandom % 1024);
    wb(1, sadc_pkg::ADDR_CONTROL, c, 0, 0);
    wb(1, sadc_pkg::ADDR_CONTROL, c | 8'h02, 0, 0);
    poll_done();
    chk(flag_o === 1'b1, "done flag");
    wb(0, sadc_pkg::ADDR_RES_HI, 0, 32'hFFFF_FFFF, j ? {30'h0, vin[9:8]} : {24'h0, vin[9:2]});
    wb(0, sadc_pkg::ADDR_RES_LO, 0, 32'hFFFF_FFFF, j ? {24'h0, vin[7:0]} : {24'h0, vin[1:0], 6'h0});
    prev = vin;
    fclr <= 1;
    @(posedge clk_i);
    fclr <= 0;
    @(posedge clk_i);
    @(posedge clk_i);
    chk(flag_o === 1'b0, "flag clear");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2_000_000;
    bad("watchdog");
    final_report();
  end
  initial begin
    void'($urandom(53));
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1;
    for (int a = 0; a < 16; a += 4) wb(0, 4'(a), 0, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1, sadc_pkg::ADDR_CLKSEL, 8'hFF, 0, 0);
    wb(0, sadc_pkg::ADDR_CLKSEL, 0, 32'hFFFF_FFFF, 32'h0000_0070);
    wb(0, 4'h2, 0, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h02, 0, 0);
    wb(0, sadc_pkg::ADDR_CONTROL, 0, 32'hFFFF_FFFF, 32'h0000_0000);
    conv(1, 4'h0);
    // divide by 16: each period outlasts the registered comparator path
    wb(1, sadc_pkg::ADDR_CLKSEL, 8'h50, 0, 0);
    foreach (codes[i]) begin
      conv(i % 2, codes[i]);
      chk(chan_o === codes[i], "channel");
    end
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h41, 0, 0);
    @(posedge clk_i);
    chk(ref_ext_o === 1'b1, "ext ref");
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h83, 0, 0);
    vin <= ~prev;
    repeat (6) @(posedge clk_i);
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h81, 0, 0);
    wb(0, sadc_pkg::ADDR_RES_LO, 0, 32'hFFFF_FFFF, {24'h0, prev[7:0]});
    chk(sample_o === 1'b0, "tracking in holdoff");
    repeat (40) @(posedge clk_i);
    chk(sample_o === 1'b1, "acquire after abort");
    trig <= 1;
    @(posedge clk_i);
    trig <= 0;
    repeat (3) @(posedge clk_i);
    chk(seen_tclr === 1'b1, "timer clear");
    wb(0, sadc_pkg::ADDR_CONTROL, 0, 32'h0000_0002, 32'h0000_0002);
    poll_done();
    wb(0, sadc_pkg::ADDR_RES_LO, 0, 32'hFFFF_FFFF, {24'h0, vin[7:0]});
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h83, 0, 0);
    repeat (20) @(posedge clk_i);
    slp <= 1;
    repeat (10) @(posedge clk_i);
    chk(aon === 1'b0, "sleep shutdown");
    wb(0, sadc_pkg::ADDR_CONTROL, 0, 32'h0000_0003, 32'h0000_0001);
    slp <= 0;
    repeat (40) @(posedge clk_i);
    chk(aon === 1'b1, "awake again");
    wb(1, sadc_pkg::ADDR_CLKSEL, 8'h70, 0, 0);
    irqe <= 1;
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h83, 0, 0);
    slp <= 1;
    poll_done();
    chk(seen_wake === 1'b1, "wake on completion");
    irqe <= 0;
    wb(1, sadc_pkg::ADDR_CONTROL, 8'h83, 0, 0);
    poll_done();
    repeat (2) @(posedge clk_i);
    chk(aon === 1'b0, "rc sleep shutdown");
    wb(0, sadc_pkg::ADDR_CONTROL, 0, 32'h0000_0001, 32'h0000_0001);
    slp <= 0;
    repeat (6) @(posedge clk_i);
    chk(aon === 1'b1, "rc wake power");
    reset_n_i <= 0;
    @(posedge clk_i);
    reset_n_i <= 1;
    wb(0, sadc_pkg::ADDR_CONTROL, 0, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(0, sadc_pkg::ADDR_CLKSEL, 0, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(aon === 1'b0, "off after reset");
    final_report();
  end
endmodule
